/* dv/plc_discrete_control_port_test.sv */
// Purpose: Self-checking bench of the discrete controller port.
// Assumes: QUAL of 4 cycles, pulses of 12 cycles, classic Wishbone.
// Notes: Status is read back over the bus; pins are sampled directly.
`timescale 1ns/1ps
`default_nettype none

module plc_discrete_control_port_test;
  import plc_port_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [5:0] mom;
  logic [2:0] lvl;
  logic rej, fil, rdy, nrdy, cok, zing, cing, rv, tv, vv;
  logic [3:0] lo, hi;
  int err_total = 0, n_compared = 0, cycles = 0;

  // 50 ns clock
  always #25 clk = ~clk;

  plc_model plc_model_inst (.clk_i(clk), .mom_o(mom), .lvl_o(lvl));

  plc_discrete_control_port #(.QUAL(4)) plc_discrete_control_port_inst (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .stop_i(mom[0]), .start_i(mom[1]), .zero_i(mom[2]), .cal_i(mom[3]),
    .dec_i(mom[4]), .inc_i(mom[5]), .port_enable_i(lvl[0]),
    .auto_range_i(lvl[1]), .hold_i(lvl[2]), .reject_o(rej),
    .filament_fault_o(fil), .ready_o(rdy), .not_ready_o(nrdy),
    .cal_ok_o(cok), .zeroing_o(zing), .calibrating_o(cing),
    .low_digit_o(lo), .high_digit_o(hi), .rough_valve_o(rv),
    .test_valve_o(tv), .vent_valve_o(vv));

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  // One classic cycle; waits for ack, the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Write, then let the two-cycle status update land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask

  task automatic report(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Register field check
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    report(q & m, e);
  endtask

  // Pin group check
  task automatic chk_pins(input logic [31:0] g, input logic [31:0] e);
    report(g, e);
  endtask

  task automatic mode(input mode_t m);
    chk_reg(STATUS_OFS, 32'h7F00, {17'h0, m, 8'h00});
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, the tests need about 420 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    // Bus idle before the first edge so reset sees no request
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_reg(STATUS_OFS, 32'h7FF7, 32'h0180);
    chk_reg(SETPT_OFS, 32'hFF, 32'h50);
    chk_pins({rdy, nrdy, vv}, 3'b011);
    plc_model_inst.pulse(1);
    mode(M_VENT);
    $display("test reset and disabled port done");
    plc_model_inst.levels(3'b001);
    plc_model_inst.pulse(1);
    mode(M_ROUGH);
    chk_pins({rv, tv, vv}, 3'b100);
    wr(SEQ_OFS, 32'h1);
    mode(M_GROSS);
    wr(SEQ_OFS, 32'h1);
    mode(M_FINE);
    chk_pins({rv, tv, vv}, 3'b010);
    $display("test start sequence done");
    plc_model_inst.pulse(3);
    mode(M_CAL);
    chk_pins({cing, cok}, 2'b10);
    wr(SEQ_OFS, 32'h3);
    mode(M_FINE);
    chk_pins({cing, cok}, 2'b01);
    plc_model_inst.pulse(2);
    chk_pins(zing, 1'b1);
    wr(SEQ_OFS, 32'h1);
    chk_pins(zing, 1'b0);
    $display("test zero and calibrate done");
    plc_model_inst.pulse(5, 40);
    chk_reg(STATUS_OFS, 32'hF0, 32'h90);
    plc_model_inst.pulse(4);
    plc_model_inst.pulse(4);
    chk_reg(STATUS_OFS, 32'hF0, 32'h70);
    plc_model_inst.levels(3'b011);
    plc_model_inst.pulse(5);
    chk_reg(STATUS_OFS, 32'hF0, 32'h70);
    wr(LEAK_OFS, 32'h95);
    chk_reg(STATUS_OFS, 32'hF0, 32'h80);
    chk_pins({hi, lo, rej}, 9'h12B);
    wr(LEAK_OFS, 32'h05);
    chk_reg(STATUS_OFS, 32'hF0, 32'h70);
    chk_pins({hi, lo, rej}, 9'h00A);
    $display("test ranging and digits done");
    wr(SETPT_OFS, 32'h130);
    chk_reg(SETPT_OFS, 32'hFF, 32'h50);
    chk_reg(RESP_OFS, 32'hFF, 32'hCA);
    wr(RESP_OFS, 32'h1);
    wr(SETPT_OFS, 32'h030);
    chk_reg(SETPT_OFS, 32'hFF, 32'h50);
    chk_reg(RESP_OFS, 32'hFF, 32'h00);
    wr(SENSE_OFS, 32'h3);
    chk_pins({fil, rdy, nrdy}, 3'b110);
    wr(SENSE_OFS, 32'h6);
    chk_pins({fil, rdy, nrdy}, 3'b001);
    // No byte lanes: the written bits are masked to zero
    wb(1'b1, SENSE_OFS, 32'h3, 4'h0);
    repeat (3) @(posedge clk);
    chk_pins({fil, rdy, nrdy}, 3'b001);
    chk_reg(STATUS_OFS, 32'h2, 32'h2);
    $display("test lockout and sense done");
    plc_model_inst.levels(3'b101);
    mode(M_HOLD);
    chk_pins({rv, tv}, 2'b00);
    plc_model_inst.levels(3'b001);
    plc_model_inst.pulse(0);
    mode(M_VENT);
    chk_pins(vv, 1'b1);
    plc_model_inst.levels(3'b000);
    plc_model_inst.pulse(1);
    mode(M_VENT);
    wr(SETPT_OFS, 32'h130);
    chk_reg(SETPT_OFS, 32'hFF, 32'h30);
    chk_reg(8'h20, 32'hFFFFFFFF, 32'h0);
    $display("test hold, stop and release done");
    stop_test();
  end
endmodule

`default_nettype wire

/* dv/plc_model.sv */
// Purpose: Controller model driving the discrete command pins.
// Assumes: Pins idle low; a pulse lasts LEN cycles of clk_i.
// Notes: LEN stands in for the 200 ms pulse, scaled with QUAL.
`timescale 1ns/1ps
`default_nettype none

module plc_model #(
  parameter int LEN = 12
) (
  // Clock
  input wire logic clk_i,
  // Momentary and level pins
  output logic [5:0] mom_o,
  output logic [2:0] lvl_o
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Idle low from time zero so nothing fires early
  initial begin
    mom_o = '0;
    lvl_o = '0;
  end

  // Pulse {inc,dec,cal,zero,start,stop}, then low long enough to rearm
  task automatic pulse(input int i, input int n = LEN);
    @(posedge clk_i);
    mom_o <= mom_o | (6'h01 << i);
    repeat (n) @(posedge clk_i);
    mom_o <= mom_o & ~(6'h01 << i);
    repeat (6) @(posedge clk_i);
  endtask

  // Levels {hold,auto,enable}; dropping enable takes control back
  task automatic levels(input logic [2:0] v);
    @(posedge clk_i);
    lvl_o <= v;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

/* rtl/level_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous level inputs.
// Assumes: Inputs come straight from isolated pins.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ls_t;

  ls_t r;
  ls_t next_r;

  // Shift pins through both stages
  always_comb begin
    next_r = r;
    next_r.s1 = pin_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_o = r.s2;

endmodule

`default_nettype wire

/* rtl/plc_discrete_control_port.sv */
// Purpose: Discrete PLC control port with mode sequencer and status pins.
// Assumes: Internal controller reaches the registers over classic Wishbone.
// Notes: Ownership follows only the enable level, never the shutdown bit.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module plc_discrete_control_port #(
  parameter int unsigned QUAL = plc_port_pkg::QUAL_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Controller pins, momentary
  input wire logic stop_i,
  input wire logic start_i,
  input wire logic zero_i,
  input wire logic cal_i,
  input wire logic dec_i,
  input wire logic inc_i,
  // Controller pins, level
  input wire logic port_enable_i,
  input wire logic auto_range_i,
  input wire logic hold_i,
  // Status pins
  output logic reject_o,
  output logic filament_fault_o,
  output logic ready_o,
  output logic not_ready_o,
  output logic cal_ok_o,
  output logic zeroing_o,
  output logic calibrating_o,
  // Leak rate digits
  output logic [3:0] low_digit_o,
  output logic [3:0] high_digit_o,
  // Valve drives
  output logic rough_valve_o,
  output logic test_valve_o,
  output logic vent_valve_o
);

  import plc_port_pkg::*;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [5:0] pins;
  logic [5:0] fire;
  logic [2:0] lvl;
  logic en;
  logic auto_rng;
  logic hold_lvl;

  assign pins = {inc_i, dec_i, cal_i, zero_i, start_i, stop_i};

  // One qualifier per momentary pin [RQ20]
  generate
    for (genvar g = 0; g < 6; g++) begin : g_pd
      pulse_detect #(.QUAL(QUAL)) u_pd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(pins[g]),
        .fire_o(fire[g])
      );
    end
  endgenerate

  level_sync #(.WIDTH(3)) u_ls (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({hold_i, auto_range_i, port_enable_i}),
    .level_o(lvl)
  );

  assign en = lvl[0];
  assign auto_rng = lvl[1];
  assign hold_lvl = lvl[2];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic [7:0] leak;
    logic [7:0] setpt;
    logic [3:0] expo;
    logic [7:0] resp;
    logic fil;
    logic run;
    logic off;
    logic new_smp;
    logic cal_ok;
    logic reject;
    logic ready;
    logic not_ready;
    logic rough;
    logic test;
    logic vent;
    logic ack;
    logic [31:0] rdat;
  } st_t;

  st_t r;
  st_t next_r;

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic seq_done;
  logic seq_pass;

  // Bus request decode; byte lanes gate write bits
  assign req = cyc_i && stb_i && !r.ack;
  assign wr = req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wd = dat_i & wmask;
  assign seq_done = wr && adr_i == SEQ_OFS && wd[SEQ_DONE_BIT];
  assign seq_pass = wd[SEQ_PASS_BIT];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ack = req;
    next_r.new_smp = 1'b0;
    next_r.rdat = '0;

    // Register writes
    if (wr) begin
      case (adr_i)
        SENSE_OFS: begin
          next_r.fil = wd[SENSE_FIL_BIT];
          next_r.run = wd[SENSE_RUN_BIT];
          next_r.off = wd[SENSE_OFF_BIT];
        end
        LEAK_OFS: begin
          next_r.leak = wd[7:0];
          next_r.new_smp = 1'b1;
        end
        SETPT_OFS: begin
          // Parameter locked while the port owns the unit [RQ9]
          if (en) begin
            next_r.resp = wd[SETPT_SRC_BIT] ? RESP_REFUSE : r.resp; // [RQ10]
          end else begin
            next_r.setpt = wd[7:0];
            next_r.resp = RESP_OK;
          end
        end
        RESP_OFS: begin
          if (wd[RESP_CLR_BIT]) begin
            next_r.resp = RESP_OK;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped reads return zero
    if (req && !we_i) begin
      case (adr_i)
        STATUS_OFS: next_r.rdat = {17'h0, r.mode, r.expo, 1'b0, r.cal_ok,
                                   en, r.reject};
        SENSE_OFS: next_r.rdat = {29'h0, r.off, r.run, r.fil};
        LEAK_OFS: next_r.rdat = {24'h0, r.leak};
        SETPT_OFS: next_r.rdat = {24'h0, r.setpt};
        RESP_OFS: next_r.rdat = {24'h0, r.resp};
        default: next_r.rdat = '0;
      endcase
    end

    // Mode sequencer; commands only while the port owns the unit [RQ8]
    // Shutdown (off) never touches ownership [RQ19]
    if (en && fire[0]) begin
      next_r.mode = M_VENT; // [RQ1]
    end else if (en && hold_lvl && r.mode != M_VENT) begin
      next_r.mode = M_HOLD; // [RQ7]
    end else if (en && fire[1] && r.mode inside {M_VENT, M_HOLD}) begin
      next_r.mode = M_ROUGH; // [RQ2]
    end else if (en && fire[2] && r.mode != M_CAL) begin
      next_r.mode = M_ZERO; // [RQ3]
    end else if (en && fire[3] && r.mode == M_FINE) begin
      next_r.mode = M_CAL; // [RQ3]
    end else if (seq_done) begin
      // Sequencer reports the end of each step
      case (r.mode)
        M_ROUGH: next_r.mode = M_GROSS; // [RQ2]
        M_GROSS: next_r.mode = M_FINE; // [RQ2]
        M_ZERO: next_r.mode = M_FINE;
        M_CAL: begin
          next_r.mode = M_FINE;
          next_r.cal_ok = seq_pass; // [RQ14]
        end
        default: begin
        end
      endcase
    end

    // Valves follow the next mode so they switch with it, from flops [RQ7]
    next_r.rough = next_r.mode inside {M_ROUGH, M_GROSS};
    next_r.test = next_r.mode inside {M_FINE, M_ZERO, M_CAL};
    next_r.vent = next_r.mode == M_VENT;

    // Range exponent, saturating at both ends
    if (en && !auto_rng) begin
      if (fire[4] && r.expo != 4'h0) begin
        next_r.expo = r.expo - 4'h1; // [RQ4]
      end else if (fire[5] && r.expo != EXPO_MAX) begin
        next_r.expo = r.expo + 4'h1; // [RQ5]
      end
    end else if (en && r.new_smp) begin
      // Step toward mid-scale one decade per sample [RQ6]
      if (r.leak > AUTO_HI && r.expo != EXPO_MAX) begin
        next_r.expo = r.expo + 4'h1;
      end else if (r.leak < AUTO_LO && r.expo != 4'h0) begin
        next_r.expo = r.expo - 4'h1;
      end
    end

    // Status pins; BCD digits compare in order as bytes [RQ11]
    next_r.reject = r.leak > r.setpt;
    next_r.ready = r.run && !r.off; // [RQ13]
    next_r.not_ready = !(r.run && !r.off); // [RQ13]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.mode <= M_VENT;
      r.setpt <= SETPT_RST;
      r.expo <= EXPO_RST;
      r.resp <= RESP_OK;
      r.not_ready <= 1'b1;
      r.vent <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign dat_o = r.rdat;
  assign ack_o = r.ack;
  assign reject_o = r.reject;
  assign filament_fault_o = r.fil; // [RQ12]
  assign ready_o = r.ready;
  assign not_ready_o = r.not_ready;
  assign cal_ok_o = r.cal_ok;
  assign zeroing_o = r.mode[5]; // [RQ15]
  assign calibrating_o = r.mode[6]; // [RQ16]
  assign low_digit_o = r.leak[3:0]; // [RQ17]
  assign high_digit_o = r.leak[7:4]; // [RQ17]
  // Hold and vent keep test and roughing paths shut [RQ7]
  assign rough_valve_o = r.rough;
  assign test_valve_o = r.test;
  assign vent_valve_o = r.vent;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence stop_seen;
    en && fire[0];
  endsequence

  sequence start_seen;
    en && fire[1] && !fire[0] && !hold_lvl && r.mode == M_VENT;
  endsequence

  stop_vent_a: assert property (stop_seen |=> vent_valve_o && !test_valve_o) // [RQ1]
    else $error("stop did not vent");
  start_rough_a: assert property (start_seen |=> r.mode == M_ROUGH
      && rough_valve_o) // [RQ2]
    else $error("start did not rough");
  zero_run_a: assert property (en && fire[2] && !fire[0] && !hold_lvl
      && r.mode == M_FINE |=> zeroing_o && !calibrating_o) // [RQ3]
    else $error("zero not started");
  manual_dec_a: assert property (en && !auto_rng && fire[4]
      && r.expo != 4'h0 |=> r.expo == $past(r.expo) - 4'h1) // [RQ4]
    else $error("decrement lost");
  manual_inc_a: assert property (en && !auto_rng && fire[5] && !fire[4]
      && r.expo != EXPO_MAX |=> r.expo == $past(r.expo) + 4'h1) // [RQ5]
    else $error("increment lost");
  hold_closed_a: assert property (en && hold_lvl && !fire[0]
      && r.mode != M_VENT |=> !rough_valve_o && !test_valve_o) // [RQ7]
    else $error("hold left a path open");
  enable_gate_a: assert property (!en && !seq_done |=> r.mode == $past(r.mode)
      && r.expo == $past(r.expo)) // [RQ8]
    else $error("command acted while disabled");
  lock_refuse_a: assert property (wr && adr_i == SETPT_OFS && en
      && wd[SETPT_SRC_BIT] |=> $stable(r.setpt)
      && r.resp == RESP_REFUSE) // [RQ9] [RQ10]
    else $error("locked write not refused");
  reject_out_a: assert property (reject_o == ($past(r.leak)
      > $past(r.setpt))) // [RQ11]
    else $error("reject wrong");
  ready_inv_a: assert property (ready_o == !not_ready_o) // [RQ13]
    else $error("ready not inverse");

endmodule

`default_nettype wire

/* rtl/plc_port_pkg.sv */
// Purpose: Shared constants and types of the discrete controller port.
// Assumes: 20 MHz clk_i, classic Wishbone register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
//
// What this block does
// RQ1: A stop pulse sends the unit to vent mode.
// RQ2: A start pulse runs roughing, gross test, then settles in fine test.
// RQ3: Zero pulse starts auto zero; calibrate pulse starts auto calibration.
// RQ4: Manual ranging: each decrement pulse lowers the range exponent by one.
// RQ5: Manual ranging: each increment pulse raises the range exponent by one.
// RQ6: Auto-range level high lets the unit adjust the exponent itself.
// RQ7: Hold input places the unit in hold, test and roughing paths closed; the code ignores hold while the unit is in vent mode.
// RQ8: Command inputs act only while the port-enable level is high.
// RQ9: Port enable high refuses parameter changes from panel or serial ports.
// RQ10: A refused serial parameter change is answered with the refusal word.
// RQ11: Reject output high while leak rate exceeds reject set point.
// RQ12: Filament-fault output high while the selected filament is broken.
// RQ13: Ready high while operating; not-ready is always its exact inverse.
// RQ14: Calibration-passed output high when the last calibration succeeded.
// RQ15: Zeroing output high while the auto zero routine runs.
// RQ16: Calibrating output high while the auto calibration routine runs.
// RQ17: Leak rate shown as two active-high BCD digits, bits A to D.
// RQ18: The controller drops port enable to take control back.
// RQ19: Control stays with the port across shutdown while enable is high.
// RQ20: Momentary inputs are synchronised and act once per rising pulse.

package plc_port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] SENSE_OFS = 8'h04;
  localparam logic [7:0] LEAK_OFS = 8'h08;
  localparam logic [7:0] SETPT_OFS = 8'h0C;
  localparam logic [7:0] RESP_OFS = 8'h10;
  localparam logic [7:0] SEQ_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SENSE_FIL_BIT = 0;
  localparam int SENSE_RUN_BIT = 1;
  localparam int SENSE_OFF_BIT = 2;
  localparam int SETPT_SRC_BIT = 8;
  localparam int SEQ_DONE_BIT = 0;
  localparam int SEQ_PASS_BIT = 1;
  localparam int RESP_CLR_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SETPT_RST = 8'h50;
  localparam logic [3:0] EXPO_RST = 4'h8;
  localparam logic [3:0] EXPO_MAX = 4'hF;
  localparam logic [7:0] AUTO_HI = 8'h90;
  localparam logic [7:0] AUTO_LO = 8'h10;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_REFUSE = 8'hCA;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int PULSE_MS = 200;
  localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
  localparam int QUAL_CYC = PULSE_CYC / 2;

  // Operating modes, one-hot
  typedef enum logic [6:0] {
    M_VENT = 7'h01,
    M_ROUGH = 7'h02,
    M_GROSS = 7'h04,
    M_FINE = 7'h08,
    M_HOLD = 7'h10,
    M_ZERO = 7'h20,
    M_CAL = 7'h40
  } mode_t;

endpackage

/* rtl/pulse_detect.sv */
// Purpose: Qualifies one momentary input and fires once per pulse.
// Assumes: Line is asynchronous to clk_i.
// Notes: Fires after QUAL cycles high; rearms only once the line is low.
`timescale 1ns/1ps
`default_nettype none

module pulse_detect #(
  parameter int unsigned QUAL = 2000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and event
  input wire logic line_i,
  output logic fire_o
);

  localparam int W = $clog2(QUAL + 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [W-1:0] cnt;
    logic armed;
    logic fire;
  } pd_t;

  pd_t r;
  pd_t next_r;

  // Glitches shorter than QUAL are dropped; held lines fire once [RQ20]
  always_comb begin
    next_r = r;
    next_r.s1 = line_i;
    next_r.s2 = r.s1;
    next_r.fire = 1'b0;
    if (!r.s2) begin
      next_r.cnt = '0;
      next_r.armed = 1'b1;
    end else if (r.armed) begin
      if (r.cnt == W'(QUAL - 1)) begin
        next_r.fire = 1'b1;
        next_r.armed = 1'b0;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
  end

  // Not armed at reset, but the cleared s2 reads low and arms it, so a line high at reset fires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fire_o = r.fire;

endmodule

`default_nettype wire
